// ---- wake_frame_clock_recovery_cfg_bench.sv ----
/*
  Self-checking bench of the clock recovery configuration block:
  register access over the serial port, resets, filter time constants,
  measuring clock selection and limit clamping.
  Assumes wfcr_core with its package and constants header.
*/
`timescale 1ns/100ps
`default_nettype none
`include "wfcr_defs.svh"

`define WFCR_CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("ERROR %0t got %0h exp %0h", $time, (got), (exp)); \
    end \
  end

module wake_frame_clock_recovery_cfg_bench;

  logic       clk;
  logic       resetn;
  logic       soft_reset;
  logic       restart;
  logic       spi_sck;
  logic       spi_csn;
  logic       spi_mosi;
  logic [7:0] btl;
  wire        spi_miso;
  wire        spi_miso_oe;
  wire        bus_rxd;
  wire  [7:0] recovered_bit_time;
  wire        recovered_valid;
  wire        recovery_active;
  int         error_cnt  = 0;
  int         checks     = 0;
  int         vcnt       = 0;

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  wfcr_core #(.CNT_W(12), .SYS_MHZ(200)) i_dut (
    .clk                     (clk),
    .resetn                  (resetn),
    .soft_reset              (soft_reset),
    .restart                 (restart),
    .spi_sck                 (spi_sck),
    .spi_csn                 (spi_csn),
    .spi_mosi                (spi_mosi),
    .spi_miso                (spi_miso),
    .spi_miso_oe             (spi_miso_oe),
    .bus_rxd                 (bus_rxd),
    .bit_time_length_setting (btl),
    .recovered_bit_time      (recovered_bit_time),
    .recovered_valid         (recovered_valid),
    .recovery_active         (recovery_active)
  );

  wfcr_can_node i_node (
    .clk     (clk),
    .bus_rxd (bus_rxd)
  );

  always @(posedge clk) begin
    if (recovered_valid === 1'b1) vcnt <= vcnt + 1;
  end

  task automatic complete_run;
    if (error_cnt == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One 16-bit frame, LSB first; read data sampled late in each low phase
  task automatic xfer(input logic [6:0] a, input logic w,
                      input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {d, w, a};
    q = 8'h00;
    @(posedge clk) spi_csn <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk) spi_mosi <= f[i];
      @(posedge clk) spi_sck <= 1'b1;
      repeat (2) @(posedge clk);
      spi_sck <= 1'b0;
      repeat (5) @(posedge clk);
      if (i >= 7 && i < 15) q[i - 7] = spi_miso;
      if (i == 15) `WFCR_CHK(spi_miso_oe, 1'b1)
    end
    spi_csn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(a, 1'b1, d, q);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    xfer(a, 1'b0, 8'h00, q);
    `WFCR_CHK(q, e)
    `WFCR_CHK(spi_miso_oe, 1'b0)
  endtask

  task automatic t_reset;
    rd_chk(`WFCR_ADDR_CTRL1, 8'h04);
    rd_chk(`WFCR_ADDR_CTRL2, 8'h00);
    rd_chk(`WFCR_ADDR_UPPER, 8'hA8);
    rd_chk(`WFCR_ADDR_LOWER, 8'h98);
  endtask

  // Reserved bits dropped, unmapped address inert, then soft reset
  task automatic t_access;
    wr(`WFCR_ADDR_CTRL1, 8'hFF);
    wr(`WFCR_ADDR_CTRL2, 8'hFF);
    wr(`WFCR_ADDR_UPPER, 8'h55);
    wr(`WFCR_ADDR_LOWER, 8'hAA);
    wr(7'h3B, 8'hFF);
    rd_chk(`WFCR_ADDR_CTRL1, 8'h0D);
    rd_chk(`WFCR_ADDR_CTRL2, 8'h03);
    rd_chk(`WFCR_ADDR_UPPER, 8'h55);
    rd_chk(`WFCR_ADDR_LOWER, 8'hAA);
    rd_chk(7'h3B, 8'h00);
    @(posedge clk) soft_reset <= 1'b1;
    @(posedge clk) soft_reset <= 1'b0;
    t_reset();
  endtask

  // Restart keeps filter and enable, reserved bits stay clear
  task automatic t_restart;
    wr(`WFCR_ADDR_CTRL1, 8'hF9);
    @(posedge clk) restart <= 1'b1;
    @(posedge clk) restart <= 1'b0;
    rd_chk(`WFCR_ADDR_CTRL1, 8'h09);
  endtask

  // Seed the filter at 40, then track a true bit time of 32 ticks;
  // edges needed to fall below 36 grow with the time constant.
  // Gaps are one cycle over a multiple of five: the restart cycle of
  // the counter is lost, so the tick count is exact at 80 MHz.
  task automatic t_filt(input logic [1:0] c, input int gap,
                        input int lo, input int hi);
    int k;
    int v0;
    wr(`WFCR_ADDR_CTRL1, 8'h00);
    @(posedge clk) btl <= 8'h28;
    repeat (4) @(posedge clk);
    `WFCR_CHK(recovery_active, 1'b0)
    wr(`WFCR_ADDR_CTRL1, {4'h0, c, 2'b01});
    @(posedge clk) btl <= 8'h20;
    `WFCR_CHK(recovery_active, 1'b1)
    k = 0;
    v0 = vcnt;
    do begin
      i_node.edge_gap(gap);
      k++;
    end while ((vcnt == v0 || recovered_bit_time >= 8'h24) && k < 40);
    `WFCR_CHK(k inside {[lo:hi]}, 1'b1)
  endtask

  task automatic t_clamp;
    int v0;
    v0 = vcnt;
    wr(`WFCR_ADDR_LOWER, 8'h30);
    i_node.edge_gap(160);
    i_node.edge_gap(160);
    `WFCR_CHK(recovered_bit_time, 8'h30)
    wr(`WFCR_ADDR_UPPER, 8'h18);
    wr(`WFCR_ADDR_LOWER, 8'h10);
    i_node.edge_gap(160);
    i_node.edge_gap(160);
    `WFCR_CHK(recovered_bit_time, 8'h18)
    `WFCR_CHK(vcnt - v0, 4)
  endtask

  // Bit time of 16 ticks keeps 11 bits far below counter overflow
  // A wrong clock rate moves the 10 or 11 bit spacing across the edge
  task automatic t_clk;
    int v0;
    int tb;
    for (int c = 0; c < 4; c++) begin
      tb = 40 << c;
      wr(`WFCR_ADDR_CTRL2, 8'(c));
      wr(`WFCR_ADDR_CTRL1, 8'h00);
      @(posedge clk) btl <= 8'h10;
      wr(`WFCR_ADDR_CTRL1, 8'h01);
      v0 = vcnt;
      i_node.edge_gap(10 * tb);
      i_node.edge_gap(11 * tb);
      `WFCR_CHK(vcnt - v0, 1)
      i_node.edge_gap(tb);
      `WFCR_CHK(vcnt - v0, 1)
    end
    wr(`WFCR_ADDR_CTRL1, 8'h00);
    v0 = vcnt;
    repeat (3) i_node.edge_gap(400);
    `WFCR_CHK(vcnt - v0, 0)
  endtask

  // Setting for 160 times the baud rate: the bit time stays on nominal
  task automatic t_recommend;
    int v0;
    wr(`WFCR_ADDR_CTRL2, 8'h00);
    @(posedge clk) btl <= 8'hA0;
    wr(`WFCR_ADDR_UPPER, 8'hA8);
    wr(`WFCR_ADDR_LOWER, 8'h98);
    wr(`WFCR_ADDR_CTRL1, 8'h01);
    v0 = vcnt;
    repeat (3) i_node.edge_gap(401);
    `WFCR_CHK(vcnt - v0, 2)
    `WFCR_CHK(recovered_bit_time, 8'hA0)
  endtask

  initial begin
    #500_000;
    error_cnt++;
    complete_run();
  end

  initial begin
    resetn     <= 1'b0;
    soft_reset <= 1'b0;
    restart    <= 1'b0;
    spi_sck    <= 1'b0;
    spi_csn    <= 1'b1;
    spi_mosi   <= 1'b0;
    btl        <= 8'h20;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_access();
    t_restart();
    wr(`WFCR_ADDR_UPPER, 8'hFF);
    wr(`WFCR_ADDR_LOWER, 8'h00);
    t_filt(2'b10, 161, 21, 30);
    t_filt(2'b01, 161, 11, 16);
    t_filt(2'b11, 161, 21, 30);
    t_filt(2'b11, 401, 11, 16);
    t_filt(2'b11, 721, 6, 10);
    t_filt(2'b00, 161, 6, 10);
    t_clamp();
    t_clk();
    // Trimming is never written, only the recovery registers
    t_recommend();
    complete_run();
  end

endmodule

`default_nettype wire

// ---- wfcr_can_node.sv ----
/*
  Bus node model that sends wake frames as dominant pulses on the
  received bus level.
  Assumes the bench clock; the line rests recessive (1) between pulses.
*/
`timescale 1ns/100ps
`default_nettype none

module wfcr_can_node (
  input  wire logic clk,
  output logic      bus_rxd
);

  initial bus_rxd = 1'b1;

  // One falling edge now, next one exactly gap cycles later
  task automatic edge_gap(input int gap);
    @(posedge clk) bus_rxd <= 1'b0;
    repeat (6) @(posedge clk);
    bus_rxd <= 1'b1;
    repeat (gap - 7) @(posedge clk);
  endtask

endmodule

`default_nettype wire

// ---- wfcr_core.sv ----
/*
  Clock and data recovery configuration: four control registers behind
  the serial port, measuring clock, edge-spacing counter, adaptive
  low-pass filter and limit clamp of the recovered bit time.
  Assumes the received bus level and resets synchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "wfcr_defs.svh"

module wfcr_core
  import wfcr_pkg::*;
#(
  parameter int CNT_W   = 12,
  parameter int SYS_MHZ = `WFCR_SYS_MHZ
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       soft_reset,
  input  wire logic       restart,
  input  wire logic       spi_sck,
  input  wire logic       spi_csn,
  input  wire logic       spi_mosi,
  output logic            spi_miso,
  output logic            spi_miso_oe,
  input  wire logic       bus_rxd,
  input  wire logic [7:0] bit_time_length_setting,
  output logic [7:0]      recovered_bit_time,
  output logic            recovered_valid,
  output logic            recovery_active
);

  localparam int ACC_W = 8 + `WFCR_FRAC_BITS;

  logic [6:0]  addr;
  logic        wr_pulse;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        wr_hit;

  wfcr_filt_t  filter_time_select;
  logic        recovery_enable;
  logic [1:0]  osc_select;
  logic [7:0]  upper_bit_time_limit;
  logic [7:0]  lower_bit_time_limit;
  wfcr_filt_t  next_filter_time_select;
  logic        next_recovery_enable;
  logic [1:0]  next_osc_select;
  logic [7:0]  next_upper_bit_time_limit;
  logic [7:0]  next_lower_bit_time_limit;

  wfcr_spi u_spi (
    .clk         (clk),
    .resetn      (resetn),
    .spi_sck     (spi_sck),
    .spi_csn     (spi_csn),
    .spi_mosi    (spi_mosi),
    .rdata       (rdata),
    .spi_miso    (spi_miso),
    .spi_miso_oe (spi_miso_oe),
    .addr        (addr),
    .wr_pulse    (wr_pulse),
    .wdata       (wdata)
  );

  function automatic logic [7:0] osc_step(input logic [1:0] sel);
    logic [7:0] s;
    unique case (sel)
      2'b00: s = `WFCR_OSC_MHZ_80;
      2'b01: s = `WFCR_OSC_MHZ_40;
      2'b10: s = `WFCR_OSC_MHZ_20;
      2'b11: s = `WFCR_OSC_MHZ_10;
    endcase
    return s;
  endfunction

  // Nearest whole number of bits in a spacing, 0 below half a bit, capped at 15
  function automatic logic [3:0] bits_of(input logic [CNT_W-1:0] c,
                                         input logic [7:0]       btl);
    logic [3:0] n;
    n = 4'd0;
    for (int i = 1; i < 16; i++) begin
      if ({c, 1'b0} >= (CNT_W+1)'((2 * i - 1) * int'(btl))) begin
        n = 4'(i);
      end
    end
    return n;
  endfunction

  function automatic logic [2:0] tc_shift(input wfcr_filt_t f,
                                          input logic [3:0] n);
    logic [2:0] s;
    unique case (f)
      WFCR_TC8:  s = `WFCR_TC8_SHIFT;
      WFCR_TC16: s = `WFCR_TC16_SHIFT;
      WFCR_TC32: s = `WFCR_TC32_SHIFT;
      WFCR_ADAPT: begin
        // Thresholds are in half bits: below 3.5 and below 8.5 bits
        if ({n, 1'b0} < {1'b0, `WFCR_SHORT_HALF}) begin
          s = `WFCR_TC32_SHIFT;
        end else if ({n, 1'b0} < `WFCR_MID_HALF) begin
          s = `WFCR_TC16_SHIFT;
        end else begin
          s = `WFCR_TC8_SHIFT;
        end
      end
    endcase
    return s;
  endfunction

  function automatic logic [7:0] clamp(input logic [7:0] v,
                                       input logic [7:0] hi,
                                       input logic [7:0] lo);
    logic [7:0] r;
    r = v;
    if (v > hi) begin
      r = hi;
    end else if (v < lo) begin
      r = lo;
    end
    return r;
  endfunction

  // Register file
  assign wr_hit = wr_pulse && (addr >= `WFCR_ADDR_CTRL1);

  always_comb begin
    rdata = 8'h00;
    unique case (addr)
      `WFCR_ADDR_CTRL1: begin
        rdata[`WFCR_FILT_MSB:`WFCR_FILT_LSB] = filter_time_select;
        rdata[`WFCR_EN_BIT] = recovery_enable;
      end
      `WFCR_ADDR_CTRL2: rdata[`WFCR_OSC_MSB:`WFCR_OSC_LSB] = osc_select;
      `WFCR_ADDR_UPPER: rdata = upper_bit_time_limit;
      `WFCR_ADDR_LOWER: rdata = lower_bit_time_limit;
      default:          rdata = 8'h00;
    endcase
  end

  always_comb begin
    next_filter_time_select   = filter_time_select;
    next_recovery_enable      = recovery_enable;
    next_osc_select           = osc_select;
    next_upper_bit_time_limit = upper_bit_time_limit;
    next_lower_bit_time_limit = lower_bit_time_limit;
    if (soft_reset) begin
      next_filter_time_select   = WFCR_TC16;
      next_recovery_enable      = `WFCR_RST_EN;
      next_osc_select           = `WFCR_RST_OSC;
      next_upper_bit_time_limit = `WFCR_RST_UPPER;
      next_lower_bit_time_limit = `WFCR_RST_LOWER;
    end else if (wr_hit) begin
      unique case (addr)
        `WFCR_ADDR_CTRL1: begin
          next_filter_time_select =
            wfcr_filt_t'(wdata[`WFCR_FILT_MSB:`WFCR_FILT_LSB]);
          next_recovery_enable = wdata[`WFCR_EN_BIT];
        end
        `WFCR_ADDR_CTRL2:
          next_osc_select = wdata[`WFCR_OSC_MSB:`WFCR_OSC_LSB];
        `WFCR_ADDR_UPPER: next_upper_bit_time_limit = wdata;
        `WFCR_ADDR_LOWER: next_lower_bit_time_limit = wdata;
        default: next_osc_select = osc_select;
      endcase
    end
    // Restart holds every stored field; reserved bits are never stored
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      filter_time_select   <= WFCR_TC16;
      recovery_enable      <= `WFCR_RST_EN;
      osc_select           <= `WFCR_RST_OSC;
      upper_bit_time_limit <= `WFCR_RST_UPPER;
      lower_bit_time_limit <= `WFCR_RST_LOWER;
    end else begin
      filter_time_select   <= next_filter_time_select;
      recovery_enable      <= next_recovery_enable;
      osc_select           <= next_osc_select;
      upper_bit_time_limit <= next_upper_bit_time_limit;
      lower_bit_time_limit <= next_lower_bit_time_limit;
    end
  end

  // Measuring clock and edge spacing
  wfcr_state_t            state;
  wfcr_state_t            next_state;
  logic [8:0]             phase;
  logic [8:0]             next_phase;
  logic [8:0]             phase_sum;
  logic                   tick;
  logic                   next_tick;
  logic                   rxd_q;
  logic                   fall;
  logic [CNT_W-1:0]       count;
  logic [CNT_W-1:0]       next_count;
  logic [ACC_W-1:0]       acc;
  logic [ACC_W-1:0]       next_acc;
  logic [7:0]             next_recovered;
  logic                   next_valid;
  logic [3:0]             nbits;
  logic [2:0]             shift;
  logic [CNT_W-1:0]       quot;
  logic [7:0]             est;
  logic signed [ACC_W+1:0] delta;
  logic [ACC_W-1:0]       acc_upd;
  logic [7:0]             val;

  // Fractional divider: 200 MHz is not a multiple of 80 MHz
  assign phase_sum = phase + {1'b0, osc_step(osc_select)};
  assign fall      = rxd_q && !bus_rxd;
  assign nbits     = bits_of(count, bit_time_length_setting);
  assign shift     = tc_shift(filter_time_select, nbits);
  assign quot      = (nbits == 4'd0) ? count : count / CNT_W'(nbits);
  assign est       = (quot > CNT_W'(8'hFF)) ? 8'hFF : quot[7:0];
  assign delta     = $signed({2'b00, est, `WFCR_FRAC_BITS'(0)})
                   - $signed({2'b00, acc});
  assign acc_upd   = ACC_W'($signed({2'b00, acc}) + (delta >>> shift));
  assign val       = clamp(acc_upd[ACC_W-1:`WFCR_FRAC_BITS],
                           upper_bit_time_limit,
                           lower_bit_time_limit);

  always_comb begin
    next_phase     = phase_sum;
    next_tick      = 1'b0;
    if (phase_sum >= 9'(SYS_MHZ)) begin
      next_phase = phase_sum - 9'(SYS_MHZ);
      next_tick  = 1'b1;
    end
    next_state     = state;
    next_count     = count;
    next_acc       = acc;
    next_recovered = recovered_bit_time;
    next_valid     = 1'b0;
    unique case (state)
      WFCR_ST_OFF: begin
        next_count = '0;
        next_acc   = {bit_time_length_setting, `WFCR_FRAC_BITS'(0)};
        if (recovery_enable) begin
          next_state = WFCR_ST_WAIT;
        end
      end
      WFCR_ST_WAIT: begin
        next_count = '0;
        if (fall) begin
          next_state = WFCR_ST_RUN;
        end
      end
      WFCR_ST_RUN: begin
        if (tick && count != '1) begin
          next_count = count + CNT_W'(1);
        end
        if (fall) begin
          next_count = '0;
          // Spacings beyond ten bits or overflowed counts carry no timing
          if (nbits != 4'd0 && nbits <= `WFCR_MAX_BITS && count != '1) begin
            next_acc       = (val == acc_upd[ACC_W-1:`WFCR_FRAC_BITS]) ?
                             acc_upd : {val, `WFCR_FRAC_BITS'(0)};
            next_recovered = val;
            next_valid     = 1'b1;
          end
        end
      end
      default: next_state = WFCR_ST_OFF;
    endcase
    if (!recovery_enable) begin
      next_state = WFCR_ST_OFF;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state              <= WFCR_ST_OFF;
      phase              <= 9'h000;
      tick               <= 1'b0;
      rxd_q              <= 1'b1;
      count              <= '0;
      acc                <= '0;
      recovered_bit_time <= 8'h00;
      recovered_valid    <= 1'b0;
    end else begin
      state              <= next_state;
      phase              <= next_phase;
      tick               <= next_tick;
      rxd_q              <= bus_rxd;
      count              <= next_count;
      acc                <= next_acc;
      recovered_bit_time <= next_recovered;
      recovered_valid    <= next_valid;
    end
  end

  assign recovery_active = (state != WFCR_ST_OFF);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_ctrl1_write;
    wr_pulse && addr == `WFCR_ADDR_CTRL1 && !soft_reset;
  endsequence

  a_reserved_read_zero: assert property (
    addr == `WFCR_ADDR_CTRL1 |-> rdata[7:4] == 4'h0 && !rdata[1])
    else $error("reserved control bits read nonzero");
  a_soft_reset_load: assert property (
    soft_reset |=> filter_time_select == WFCR_TC16 && !recovery_enable)
    else $error("soft reset did not load filter code 01");
  a_restart_holds: assert property (
    restart && !soft_reset && !wr_pulse |=>
      filter_time_select == $past(filter_time_select)
      && recovery_enable == $past(recovery_enable))
    else $error("restart altered filter or enable");
  a_ctrl1_write_takes: assert property (
    s_ctrl1_write |=> filter_time_select == $past(wdata[3:2])
      ##1 $stable(filter_time_select) [*2])
    else $error("control one write not applied");
  a_fixed_tc_shift: assert property (
    filter_time_select != WFCR_ADAPT |->
      shift == 3'(filter_time_select) + `WFCR_TC8_SHIFT)
    else $error("fixed time constant wrong");
  a_adapt_tc_shift: assert property (
    filter_time_select == WFCR_ADAPT && nbits >= 4'd2 |->
      (nbits <= 4'd3 && shift == 3'd5) || (nbits inside {[4:8]}
      && shift == 3'd4) || (nbits >= 4'd9 && shift == 3'd3))
    else $error("adaptive time constant wrong");
  a_upper_clamp: assert property (
    recovered_valid && lower_bit_time_limit <= upper_bit_time_limit
      |-> recovered_bit_time <= upper_bit_time_limit)
    else $error("bit time above upper limit");
  a_lower_clamp: assert property (
    recovered_valid && lower_bit_time_limit <= upper_bit_time_limit
      |-> recovered_bit_time >= lower_bit_time_limit)
    else $error("bit time below lower limit");
  a_disabled_idle: assert property (
    !recovery_enable |=> !recovery_active ##1 !recovered_valid)
    else $error("recovery active while disabled");
  a_tick_rate_slow: assert property (
    osc_select == 2'b11 && $past(osc_select) == 2'b11 && tick |=>
      !tick [*8])
    else $error("10 MHz tick too fast");

endmodule

`default_nettype wire

// ---- wfcr_defs.svh ----
/*
  Constants of the wake-frame clock recovery configuration block:
  serial frame layout, register addresses, reset values, field positions
  and filter figures.
  Assumes inclusion by bare name from every file that needs them.
*/
// Notes on behaviour
// - Filter codes 00, 01 and 10 select time constants 8, 16 and 32.
// - Filter code 11 picks 32 for 2-3 bit, 16 for 4-8, 8 for 9-10 bit edge spacing.
// - Power-on and soft reset leave filter code 01, so control one reads 0x04.
// - Unused bits of both control registers and bit 1 of control one read 0.
// - Clock select 00, 01, 10, 11 gives an 80, 40, 20 or 10 MHz measuring clock.
// - A recovered bit time above the upper limit register is clamped to it.
// - A recovered bit time below the lower limit register is clamped to it, unless it is also above the upper limit, which then wins.
// - A restart changes no register: the unused bits of control one are never stored, and filter and enable keep their values.
`ifndef WFCR_DEFS_SVH
`define WFCR_DEFS_SVH

`define WFCR_FRAME_BITS   5'd16
`define WFCR_ADDR_DONE    5'd7
`define WFCR_DATA_START   5'd8
`define WFCR_WR_BIT       7

`define WFCR_ADDR_CTRL1   7'h3C
`define WFCR_ADDR_CTRL2   7'h3D
`define WFCR_ADDR_UPPER   7'h3E
`define WFCR_ADDR_LOWER   7'h3F

`define WFCR_RST_EN       1'b0
`define WFCR_RST_OSC      2'h0
`define WFCR_RST_UPPER    8'hA8
`define WFCR_RST_LOWER    8'h98

`define WFCR_EN_BIT       0
`define WFCR_FILT_LSB     2
`define WFCR_FILT_MSB     3
`define WFCR_OSC_LSB      0
`define WFCR_OSC_MSB      1

`define WFCR_SYS_MHZ      200
`define WFCR_OSC_MHZ_80   8'd80
`define WFCR_OSC_MHZ_40   8'd40
`define WFCR_OSC_MHZ_20   8'd20
`define WFCR_OSC_MHZ_10   8'd10

`define WFCR_TC8_SHIFT    3'd3
`define WFCR_TC16_SHIFT   3'd4
`define WFCR_TC32_SHIFT   3'd5
`define WFCR_FRAC_BITS    5
`define WFCR_MAX_BITS     4'd10
`define WFCR_SHORT_HALF   4'd7
`define WFCR_MID_HALF     5'd17

`endif

// ---- wfcr_pkg.sv ----
/*
  Types of the wake-frame clock recovery configuration block.
  Assumes nothing of its surroundings.
*/
package wfcr_pkg;

  typedef enum logic [1:0] {
    WFCR_TC8   = 2'b00,
    WFCR_TC16  = 2'b01,
    WFCR_TC32  = 2'b10,
    WFCR_ADAPT = 2'b11
  } wfcr_filt_t;

  typedef enum logic [1:0] {
    WFCR_ST_OFF  = 2'b00,
    WFCR_ST_WAIT = 2'b01,
    WFCR_ST_RUN  = 2'b10
  } wfcr_state_t;

endpackage

// ---- wfcr_spi.sv ----
/*
  Serial control port slave: 16-bit frames, LSB first, address in bits
  0..6, write flag in bit 7, data byte in bits 8..15.
  Assumes sck, csn and mosi synchronous to clk and much slower than it.
*/
`timescale 1ns/100ps
`default_nettype none
`include "wfcr_defs.svh"

module wfcr_spi
  import wfcr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       spi_sck,
  input  wire logic       spi_csn,
  input  wire logic       spi_mosi,
  input  wire logic [7:0] rdata,
  output logic            spi_miso,
  output logic            spi_miso_oe,
  output logic [6:0]      addr,
  output logic            wr_pulse,
  output logic [7:0]      wdata
);

  logic        sck_q;
  logic        csn_q;
  logic [4:0]  cnt;
  logic [15:0] shift;
  logic [7:0]  out;
  logic        next_sck_q;
  logic        next_csn_q;
  logic [4:0]  next_cnt;
  logic [15:0] next_shift;
  logic [7:0]  next_out;
  logic        next_miso;
  logic [6:0]  next_addr;
  logic        next_wr_pulse;
  logic [7:0]  next_wdata;

  always_comb begin
    next_sck_q    = spi_sck;
    next_csn_q    = spi_csn;
    next_cnt      = cnt;
    next_shift    = shift;
    next_out      = out;
    next_miso     = spi_miso;
    next_addr     = addr;
    next_wr_pulse = 1'b0;
    next_wdata    = wdata;
    if (spi_csn) begin
      next_cnt  = 5'd0;
      next_miso = 1'b0;
      // Only a frame of 16 or more bits writes; short frames are dropped, bits past the 16th are ignored
      if (!csn_q && cnt == `WFCR_FRAME_BITS) begin
        next_wr_pulse = shift[`WFCR_WR_BIT];
        next_wdata    = shift[15:8];
      end
    end else if (spi_sck && !sck_q && cnt != `WFCR_FRAME_BITS) begin
      next_shift = {spi_mosi, shift[15:1]};
      next_cnt   = cnt + 5'd1;
      if (cnt == `WFCR_ADDR_DONE) begin
        next_addr = next_shift[14:8];
      end
    end else if (!spi_sck && sck_q) begin
      if (cnt == `WFCR_DATA_START) begin
        next_miso = rdata[0];
        next_out  = {1'b0, rdata[7:1]};
      end else if (cnt > `WFCR_DATA_START) begin
        next_miso = out[0];
        next_out  = {1'b0, out[7:1]};
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sck_q    <= 1'b0;
      csn_q    <= 1'b1;
      cnt      <= 5'd0;
      shift    <= 16'h0000;
      out      <= 8'h00;
      spi_miso <= 1'b0;
      addr     <= 7'h00;
      wr_pulse <= 1'b0;
      wdata    <= 8'h00;
    end else begin
      sck_q    <= next_sck_q;
      csn_q    <= next_csn_q;
      cnt      <= next_cnt;
      shift    <= next_shift;
      out      <= next_out;
      spi_miso <= next_miso;
      addr     <= next_addr;
      wr_pulse <= next_wr_pulse;
      wdata    <= next_wdata;
    end
  end

  assign spi_miso_oe = !spi_csn;

endmodule

`default_nettype wire
